// File: verilog/wkgate_regs.vh
// Register indices, field positions and reset values of the wake gate.
`ifndef WKGATE_REGS_VH
`define WKGATE_REGS_VH

// APB address and data widths, pin group width and interrupt field width.
`define WKG_ADDR_W        8
`define WKG_DATA_W        32
`define WKG_GRP_W         8
`define WKG_IRQ_W         3

// Register indices; the byte address is four times the index.
`define WKG_IDX_W         6
`define WKG_IDX_MSB       7
`define WKG_IDX_LSB       2
`define WKG_IDX_EN4       6'h0D
`define WKG_IDX_EN5       6'h0E
`define WKG_IDX_RSVD      6'h0F
`define WKG_IDX_CTRL      6'h20
`define WKG_IDX_STS4      6'h21
`define WKG_IDX_STS5      6'h22
`define WKG_IDX_IRQ_STS   6'h23
`define WKG_IDX_IRQ_MASK  6'h24

// Reset values.
`define WKG_EN_RST        8'h00
`define WKG_STS_RST       8'h00
`define WKG_IRQ_RST       3'h0
`define WKG_CTRL_RST      1'h0
`define WKG_BIT_RST       1'h0
`define WKG_WAKE_N_RST    1'h1
`define WKG_DATA_ZERO     32'h00000000
`define WKG_ZERO_PAD8     24'h000000
`define WKG_ZERO_PAD3     29'h00000000
`define WKG_ZERO_PAD1     31'h00000000

// Control register field.
`define WKG_CTRL_GLOBAL   0

// Interrupt status and mask fields.
`define WKG_IRQ_GRP4      0
`define WKG_IRQ_GRP5      1
`define WKG_IRQ_WAKE      2

`endif

// File: verilog/wkgate_sync.v
// Two-flop synchroniser for a bus of independent level inputs.
module wkgate_sync #(
  parameter W = 8
) (
  // Clock and reset.
  input  wire         i_ref_clk,
  input  wire         i_rst_b,
  // Asynchronous levels in, synchronised levels out.
  input  wire [W-1:0] i_async,
  output wire [W-1:0] o_sync
);

  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  // The first stage feeds only the second stage.
  always @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;

endmodule // wkgate_sync

// File: verilog/wkgate_stsreg.v
// Sticky status register: hardware sets, software clears by writing one.
module wkgate_stsreg #(
  parameter W = 8
) (
  // Clock and reset.
  input  wire         i_ref_clk,
  input  wire         i_rst_b,
  // Set and clear strobes, one cycle each.
  input  wire [W-1:0] i_set,
  input  wire [W-1:0] i_clr,
  // Stored status.
  output wire [W-1:0] o_sts
);

  reg  [W-1:0] sts_q;
  wire [W-1:0] sts_d;

  // A set in the same cycle as a clear wins, so no event is lost.
  assign sts_d = (sts_q & ~i_clr) | i_set;

  always @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      sts_q <= {W{1'b0}};
    end else begin
      sts_q <= sts_d;
    end
  end

  assign o_sts = sts_q;

endmodule // wkgate_stsreg

// File: verilog/wkgate_top.v
// Wake enable gating for pin groups four and five with an APB slave.
//
// Behaviour
// - Wake request asserts only if enable, latched status, global enable.
// - Disabled sources still latch status but never drive the wake request.
// - Enable index 0D bits map gpio_3_0..3_3, 4_1, 4_3, 6_0, 6_1.
// - Enable index 0E bits map gpio_5_0 through gpio_5_7 ascending.
// - Enable registers clear to zero only on standby rail power-on reset.
// - Index 0F reads zero in all bits; writes are ignored.
//
// The APB interface to the registers was left to the implementer.
`include "wkgate_regs.vh"

module wkgate_top (
  // Clock and standby rail power-on reset.
  input  wire                     i_ref_clk,
  input  wire                     i_rst_b,
  // APB slave.
  input  wire                     i_psel,
  input  wire                     i_penable,
  input  wire                     i_pwrite,
  input  wire [`WKG_ADDR_W-1:0]   i_paddr,
  input  wire [`WKG_DATA_W-1:0]   i_pwdata,
  output wire [`WKG_DATA_W-1:0]   o_prdata,
  output wire                     o_pready,
  output wire                     o_pslverr,
  // Wake source pins, bit order as the enable registers.
  input  wire [`WKG_GRP_W-1:0]    i_gpio_grp4,
  input  wire [`WKG_GRP_W-1:0]    i_gpio_grp5,
  // Shared wake request to the platform and local interrupt.
  output wire                     o_wake_request_n,
  output wire                     o_irq
);

  // Enable and control registers.
  reg  [`WKG_GRP_W-1:0]  en4_q;
  reg  [`WKG_GRP_W-1:0]  en4_d;
  reg  [`WKG_GRP_W-1:0]  en5_q;
  reg  [`WKG_GRP_W-1:0]  en5_d;
  reg                    global_q;
  reg                    global_d;
  reg  [`WKG_IRQ_W-1:0]  irq_mask_q;
  reg  [`WKG_IRQ_W-1:0]  irq_mask_d;

  // APB answer registers.
  reg  [`WKG_DATA_W-1:0] prdata_q;
  reg  [`WKG_DATA_W-1:0] prdata_d;
  reg                    pready_q;
  reg                    pslverr_q;
  reg                    pslverr_d;

  // Output registers.
  reg                    wake_n_q;
  reg                    irq_q;
  reg                    wake_pend_q;

  // Pin edge detection.
  reg  [`WKG_GRP_W-1:0]  prev4_q;
  reg  [`WKG_GRP_W-1:0]  prev5_q;
  wire [`WKG_GRP_W-1:0]  sync4;
  wire [`WKG_GRP_W-1:0]  sync5;
  wire [`WKG_GRP_W-1:0]  rise4;
  wire [`WKG_GRP_W-1:0]  rise5;

  // Status registers and their clear strobes.
  wire [`WKG_GRP_W-1:0]  sts4;
  wire [`WKG_GRP_W-1:0]  sts5;
  wire [`WKG_IRQ_W-1:0]  irq_sts;
  reg  [`WKG_GRP_W-1:0]  clr4;
  reg  [`WKG_GRP_W-1:0]  clr5;
  reg  [`WKG_IRQ_W-1:0]  clr_irq;
  wire [`WKG_IRQ_W-1:0]  irq_set;

  // Bus decode.
  wire [`WKG_IDX_W-1:0]  idx;
  wire                   setup;
  wire                   wr_acc;
  reg                    mapped;

  // Qualified sources.
  wire [`WKG_GRP_W-1:0]  qual4;
  wire [`WKG_GRP_W-1:0]  qual5;
  wire                   wake_pend;

  wkgate_sync #(
    .W (`WKG_GRP_W)
  ) u_sync4 (
    .i_ref_clk (i_ref_clk),
    .i_rst_b   (i_rst_b),
    .i_async   (i_gpio_grp4),
    .o_sync    (sync4)
  );

  wkgate_sync #(
    .W (`WKG_GRP_W)
  ) u_sync5 (
    .i_ref_clk (i_ref_clk),
    .i_rst_b   (i_rst_b),
    .i_async   (i_gpio_grp5),
    .o_sync    (sync5)
  );

  // A wake event is the rising edge of a synchronised pin level.
  always @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      prev4_q <= `WKG_STS_RST;
      prev5_q <= `WKG_STS_RST;
    end else begin
      prev4_q <= sync4;
      prev5_q <= sync5;
    end
  end

  assign rise4 = sync4 & ~prev4_q;
  assign rise5 = sync5 & ~prev5_q;

  // Status latches regardless of enable, so a disabled pin is still seen.
  wkgate_stsreg #(
    .W (`WKG_GRP_W)
  ) u_sts4 (
    .i_ref_clk (i_ref_clk),
    .i_rst_b   (i_rst_b),
    .i_set     (rise4),
    .i_clr     (clr4),
    .o_sts     (sts4)
  );

  wkgate_stsreg #(
    .W (`WKG_GRP_W)
  ) u_sts5 (
    .i_ref_clk (i_ref_clk),
    .i_rst_b   (i_rst_b),
    .i_set     (rise5),
    .i_clr     (clr5),
    .o_sts     (sts5)
  );

  // Bit i of each group's enable gates only bit i of the same group.
  assign qual4 = en4_q & sts4;
  assign qual5 = en5_q & sts5;
  assign wake_pend = global_q & ((|qual4) | (|qual5));

  // Interrupt events: new status in either group, wake request raised.
  assign irq_set[`WKG_IRQ_GRP4] = |rise4;
  assign irq_set[`WKG_IRQ_GRP5] = |rise5;
  assign irq_set[`WKG_IRQ_WAKE] = wake_pend & ~wake_pend_q;

  wkgate_stsreg #(
    .W (`WKG_IRQ_W)
  ) u_irq_sts (
    .i_ref_clk (i_ref_clk),
    .i_rst_b   (i_rst_b),
    .i_set     (irq_set),
    .i_clr     (clr_irq),
    .o_sts     (irq_sts)
  );

  // APB decode: ready is registered from the setup cycle, so no access has a wait state.
  assign idx    = i_paddr[`WKG_IDX_MSB:`WKG_IDX_LSB];
  assign setup  = i_psel & ~i_penable;
  assign wr_acc = i_psel & i_penable & pready_q & i_pwrite;

  always @* begin
    mapped   = 1'b1;
    prdata_d = `WKG_DATA_ZERO;
    case (idx)
      `WKG_IDX_EN4:      prdata_d = {`WKG_ZERO_PAD8, en4_q};
      `WKG_IDX_EN5:      prdata_d = {`WKG_ZERO_PAD8, en5_q};
      `WKG_IDX_RSVD:     prdata_d = `WKG_DATA_ZERO;
      `WKG_IDX_CTRL:     prdata_d = {`WKG_ZERO_PAD1, global_q};
      `WKG_IDX_STS4:     prdata_d = {`WKG_ZERO_PAD8, sts4};
      `WKG_IDX_STS5:     prdata_d = {`WKG_ZERO_PAD8, sts5};
      `WKG_IDX_IRQ_STS:  prdata_d = {`WKG_ZERO_PAD3, irq_sts};
      `WKG_IDX_IRQ_MASK: prdata_d = {`WKG_ZERO_PAD3, irq_mask_q};
      default: begin
        mapped   = 1'b0;
        prdata_d = `WKG_DATA_ZERO;
      end
    endcase
    pslverr_d = ~mapped;
  end

  // Register writes; the reserved index falls to the default branch, which changes nothing.
  always @* begin
    en4_d      = en4_q;
    en5_d      = en5_q;
    global_d   = global_q;
    irq_mask_d = irq_mask_q;
    clr4       = `WKG_STS_RST;
    clr5       = `WKG_STS_RST;
    clr_irq    = `WKG_IRQ_RST;
    if (wr_acc) begin
      case (idx)
        `WKG_IDX_EN4:      en4_d = i_pwdata[`WKG_GRP_W-1:0];
        `WKG_IDX_EN5:      en5_d = i_pwdata[`WKG_GRP_W-1:0];
        `WKG_IDX_CTRL:     global_d = i_pwdata[`WKG_CTRL_GLOBAL];
        `WKG_IDX_STS4:     clr4 = i_pwdata[`WKG_GRP_W-1:0];
        `WKG_IDX_STS5:     clr5 = i_pwdata[`WKG_GRP_W-1:0];
        `WKG_IDX_IRQ_STS:  clr_irq = i_pwdata[`WKG_IRQ_W-1:0];
        `WKG_IDX_IRQ_MASK: irq_mask_d = i_pwdata[`WKG_IRQ_W-1:0];
        default: begin
          en4_d = en4_q;
        end
      endcase
    end
  end

  // Only the standby rail power-on reset reaches the enables; other
  // resets of the host never enter this block, so they cannot clear them.
  always @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      en4_q      <= `WKG_EN_RST;
      en5_q      <= `WKG_EN_RST;
      global_q   <= `WKG_CTRL_RST;
      irq_mask_q <= `WKG_IRQ_RST;
    end else begin
      en4_q      <= en4_d;
      en5_q      <= en5_d;
      global_q   <= global_d;
      irq_mask_q <= irq_mask_d;
    end
  end

  // Answer registers: read data and error are captured in the setup
  // cycle and held through the access cycle.
  always @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      prdata_q  <= `WKG_DATA_ZERO;
      pready_q  <= `WKG_BIT_RST;
      pslverr_q <= `WKG_BIT_RST;
    end else if (setup) begin
      prdata_q  <= i_pwrite ? `WKG_DATA_ZERO : prdata_d;
      pready_q  <= 1'b1;
      pslverr_q <= pslverr_d;
    end else begin
      prdata_q  <= `WKG_DATA_ZERO;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  // Outputs are registered, adding one cycle from cause to pin.
  always @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      wake_pend_q <= `WKG_BIT_RST;
      wake_n_q    <= `WKG_WAKE_N_RST;
      irq_q       <= `WKG_BIT_RST;
    end else begin
      wake_pend_q <= wake_pend;
      wake_n_q    <= ~wake_pend;
      irq_q       <= |(irq_sts & irq_mask_q);
    end
  end

  assign o_prdata         = prdata_q;
  assign o_pready         = pready_q;
  assign o_pslverr        = pslverr_q;
  assign o_wake_request_n = wake_n_q;
  assign o_irq            = irq_q;

endmodule // wkgate_top

// File: sim/wegg_checker_properties.sv
// Checker of the wake gate's APB answers and wake request gating.
module wegg_checker (
  // Clock, reset and APB.
  input wire        i_ref_clk, i_rst_b, i_psel, i_penable, i_pwrite,
  input wire [7:0]  i_paddr,
  input wire [31:0] i_pwdata,
  input wire [31:0] o_prdata,
  input wire        o_pready, o_pslverr,
  // Pins and wake outputs.
  input wire [7:0]  i_gpio_grp4, i_gpio_grp5,
  input wire        o_wake_request_n, o_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);
  // Shadow of the global enable, tracked from completed bus writes.
  reg  glob_q;
  wire setup = i_psel && !i_penable;
  always @(posedge i_ref_clk) begin
    if (!i_rst_b)
      glob_q <= 1'h0;
    else if (i_psel && i_penable && o_pready && i_pwrite && i_paddr == 8'h80)
      glob_q <= i_pwdata[0];
  end
  ready_pulse_a: assert property (o_pready |=> !o_pready)
    else $error("pready held longer than one cycle");
  ready_cause_a: assert property (setup |=> o_pready)
    else $error("no answer one cycle after setup");
  ready_only_a: assert property (o_pready |-> $past(setup))
    else $error("pready without a setup cycle");
  idle_quiet_a: assert property (!o_pready |-> o_prdata == 32'h0 && !o_pslverr)
    else $error("read data or error outside an answer");
  upper_zero_a: assert property (o_pready |-> o_prdata[31:8] == 24'h0)
    else $error("upper read data bits not zero");
  rsvd_read_a: assert property (setup && i_paddr == 8'h3C |=>
    o_prdata == 32'h0 && !o_pslverr) else $error("reserved read not zero");
  unmapped_err_a: assert property (setup && i_paddr == 8'hFC |=> o_pslverr)
    else $error("unmapped access without error");
  write_data_a: assert property (setup && i_pwrite |=> o_prdata == 32'h0)
    else $error("write answered with data");
  global_gate_a: assert property (!o_wake_request_n |-> $past(glob_q))
    else $error("wake request while global enable is off");
  cover property ($fell(o_wake_request_n));
  cover property (o_pready && o_pslverr);
  cover property (setup && i_paddr == 8'h3C);
endmodule // wegg_checker

bind wkgate_top wegg_checker chk_u (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b),
  .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
  .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
  .o_pready(o_pready), .o_pslverr(o_pslverr), .i_gpio_grp4(i_gpio_grp4),
  .i_gpio_grp5(i_gpio_grp5), .o_wake_request_n(o_wake_request_n),
  .o_irq(o_irq));

// File: sim/wegg_host_model.sv
// Host-side wake receiver that counts wake request assertions.
module wegg_host_model (
  input  wire        i_ref_clk,
  input  wire        i_rst_b,
  input  wire        i_wake_request_n,
  output logic [7:0] o_wake_count
);
  timeunit 1ns;
  timeprecision 1ns;
  logic prev_q;
  // The request is a level; only its falling edge is a new wake.
  always @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      prev_q       <= 1'h1;
      o_wake_count <= 8'h00;
    end else begin
      prev_q <= i_wake_request_n;
      if (prev_q && !i_wake_request_n)
        o_wake_count <= o_wake_count + 8'h01;
    end
  end
endmodule // wegg_host_model

// File: sim/wake_enable_gating_groups_4_5_tb.sv
// Self-checking bench of the wake gate over APB and wake pins.
module wake_enable_gating_groups_4_5_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_ref_clk = 1'h0, i_rst_b = 1'h0, i_psel = 1'h0;
  logic i_penable = 1'h0, i_pwrite = 1'h0, err;
  logic [7:0]  i_paddr = 8'h00, i_gpio_grp4 = 8'h00, i_gpio_grp5 = 8'h00, en;
  logic [31:0] i_pwdata = 32'h0, rd;
  logic [15:0] lfsr_q = 16'h000D;
  wire  [31:0] o_prdata;
  wire         o_pready, o_pslverr, o_wake_request_n, o_irq;
  wire  [7:0]  wake_cnt;
  int n_errors = 0, samples_checked = 0, exp_wakes = 0;

  wkgate_top dut_u (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
    .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_gpio_grp4(i_gpio_grp4),
    .i_gpio_grp5(i_gpio_grp5), .o_wake_request_n(o_wake_request_n),
    .o_irq(o_irq));
  wegg_host_model host_u (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b),
    .i_wake_request_n(o_wake_request_n), .o_wake_count(wake_cnt));

  initial forever #50 i_ref_clk = ~i_ref_clk;

  function automatic logic [7:0] rnd();
    lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    return lfsr_q[7:0];
  endfunction
  function automatic logic exp_wake(input logic [7:0] e, input logic [2:0] b);
    return ~e[b];
  endfunction

  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp, input string msg);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: %s got %h", $time, msg, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_ref_clk);
  endtask
  // Entered just after a rising edge; returns one edge after pready.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    i_psel <= 1'h1;
    i_penable <= 1'h0;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_ref_clk);
    i_penable <= 1'h1;
    n = 0;
    do begin
      @(posedge i_ref_clk);
      n++;
    end while (o_pready !== 1'h1 && n < 20);
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'h0;
    i_penable <= 1'h0;
    // An idle edge keeps the next call from driving psel twice in one step.
    if (o_pready === 1'h1) begin
      @(posedge i_ref_clk);
    end else begin
      n_errors++;
      $display("mismatch at %0t: no bus answer", $time);
      final_report();
    end
  endtask

  initial begin
    cyc(16);
    i_rst_b <= 1'h1;
    cyc(1);
    for (int a = 8'h34; a <= 8'h3C; a += 4) begin
      apb(1'h0, a[7:0], 32'h0);
      chk(rd, 32'h0, "reset value");
    end
    $display("test reset done");
    repeat (4) begin
      en = rnd();
      apb(1'h1, 8'h34, {24'h0, en});
      apb(1'h0, 8'h34, 32'h0);
      chk(rd, {24'h0, en}, "group four enable");
      en = rnd();
      apb(1'h1, 8'h38, {24'h0, en});
      apb(1'h0, 8'h38, 32'h0);
      chk(rd, {24'h0, en}, "group five enable");
    end
    apb(1'h1, 8'h3C, 32'hFFFFFFFF);
    apb(1'h0, 8'h3C, 32'h0);
    chk(rd, 32'h0, "reserved read");
    chk(err, 32'h0, "reserved error");
    apb(1'h0, 8'hFC, 32'h0);
    chk(err, 32'h1, "unmapped error");
    $display("test registers done");
    apb(1'h1, 8'h34, 32'hFF);
    i_gpio_grp4 <= 8'h01;
    cyc(6);
    chk(o_wake_request_n, 32'h1, "global off");
    apb(1'h1, 8'h90, 32'h4);
    apb(1'h1, 8'h80, 32'h1);
    cyc(2);
    exp_wakes++;
    chk(o_wake_request_n, 32'h0, "global on");
    cyc(2);
    chk(o_irq, 32'h1, "irq raised");
    apb(1'h1, 8'h90, 32'h0);
    cyc(2);
    chk(o_irq, 32'h0, "irq masked");
    apb(1'h1, 8'h90, 32'h4);
    apb(1'h1, 8'h8C, 32'h7);
    cyc(2);
    chk(o_irq, 32'h0, "irq cleared");
    i_gpio_grp4 <= 8'h00;
    apb(1'h1, 8'h84, 32'hFF);
    cyc(2);
    chk(o_wake_request_n, 32'h1, "status cleared");
    $display("test global and irq done");
    for (int i = 0; i < 16; i++) begin
      en = rnd();
      apb(1'h1, i < 8 ? 8'h34 : 8'h38, {24'h0, en});
      if (i < 8)
        i_gpio_grp4 <= 8'h01 << i;
      else
        i_gpio_grp5 <= 8'h01 << (i - 8);
      cyc(6);
      chk(o_wake_request_n, exp_wake(en, i[2:0]), "gate");
      apb(1'h0, i < 8 ? 8'h84 : 8'h88, 32'h0);
      chk(rd, 32'h1 << i[2:0], "status latched");
      exp_wakes += en[i[2:0]];
      i_gpio_grp4 <= 8'h00;
      i_gpio_grp5 <= 8'h00;
      apb(1'h1, i < 8 ? 8'h84 : 8'h88, 32'hFF);
      cyc(2);
      chk(o_wake_request_n, 32'h1, "released");
    end
    $display("test gating done");
    apb(1'h1, 8'h38, 32'h3);
    i_gpio_grp5 <= 8'h03;
    cyc(6);
    exp_wakes++;
    apb(1'h1, 8'h88, 32'h1);
    cyc(2);
    chk(o_wake_request_n, 32'h0, "one source left");
    apb(1'h1, 8'h88, 32'h2);
    cyc(2);
    chk(o_wake_request_n, 32'h1, "no source left");
    i_gpio_grp5 <= 8'h00;
    cyc(1);
    chk(wake_cnt, exp_wakes, "host wake count");
    $display("test shared request done");
    chk(o_irq, 32'h1, "irq pending");
    i_rst_b <= 1'h0;
    cyc(3);
    i_rst_b <= 1'h1;
    cyc(1);
    apb(1'h0, 8'h38, 32'h0);
    chk(rd, 32'h0, "enable after reset");
    chk(o_irq, 32'h0, "irq after reset");
    $display("test late reset done");
    final_report();
  end
endmodule // wake_enable_gating_groups_4_5_tb
